// ---- src/aeif_top.sv ----
// alarm and error event flags with clear-on-read and interrupt output
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "aeif_regs.svh"

// Contract
// - line code violation sets bit 3
// - bits reset zero, cleared by read
// - out-of-frame change sets bit 2
// - out-of-frame after criterion errored alignments
// - all-ones alarm change sets bit 1
// - remote alarm change sets bit 0
// - per-event enable gates interrupt
// - block enable masks whole group at irq; irq_summary ignores it
// - all-ones alarm two frames, zeros clear
// - remote alarm two frames each way
module aeif_top
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input aeif_pkg::aeif_bus_t bus,
  output logic [7:0] rdata,
  input wire logic line_code_violation,
  input aeif_pkg::aeif_rx_t rx,
  output logic irq,
  output logic irq_summary
);
  import aeif_pkg::*;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enable_reg;
  logic [2:0] crit_reg;
  logic block_en_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] event_vec;
  logic oof_state;
  logic ais_state;
  logic yel_state;
  logic oof_d_reg;
  logic ais_d_reg;
  logic yel_d_reg;
  logic flags_rd;
  logic [7:0] rdata_next;

  // ****************************************************************
  // defect detectors
  // ****************************************************************
  aeif_detect u_detect
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rx(rx),
    .crit(crit_reg),
    .oof_reg(oof_state),
    .ais_reg(ais_state),
    .yel_reg(yel_state)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      oof_d_reg <= 1'b0;
      ais_d_reg <= 1'b0;
      yel_d_reg <= 1'b0;
    end
    else
    begin
      oof_d_reg <= oof_state;
      ais_d_reg <= ais_state;
      yel_d_reg <= yel_state;
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  always_comb
  begin
    event_vec = 8'h00;
    event_vec[`AEIF_BIT_LCV] = line_code_violation;
    event_vec[`AEIF_BIT_OOF] = oof_state ^ oof_d_reg;
    event_vec[`AEIF_BIT_AIS] = ais_state ^ ais_d_reg;
    event_vec[`AEIF_BIT_YEL] = yel_state ^ yel_d_reg;
  end

  assign flags_rd = bus.rd && (bus.addr == `AEIF_OFS_FLAGS);

  always_comb
  begin
    flags_next = flags_reg;
    if (flags_rd)
      flags_next = 8'h00;
    flags_next = flags_next | event_vec;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flags_reg <= `AEIF_RST_FLAGS;
    else
      flags_reg <= flags_next;
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      enable_reg <= `AEIF_RST_ENABLE;
      crit_reg <= `AEIF_RST_CRIT;
      block_en_reg <= 1'b0;
      irq_mask_reg <= 8'h00;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        `AEIF_OFS_ENABLE: enable_reg <= bus.wdata & 8'h0F;
        `AEIF_OFS_FRAMING_CTRL: crit_reg <= bus.wdata[2:0];
        `AEIF_OFS_BLOCK_EN: block_en_reg <= bus.wdata[`AEIF_BIT_BLOCK_EN];
        `AEIF_OFS_IRQ_MASK: irq_mask_reg <= bus.wdata & 8'h0F;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // summary status, write one to clear
  // ****************************************************************
  // sticky copy so software can poll without destroying the event flags
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_stat_reg <= 8'h00;
    else if (bus.wr && bus.addr == `AEIF_OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~bus.wdata) | event_vec;
    else
      irq_stat_reg <= irq_stat_reg | event_vec;
  end

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      irq_summary <= 1'b0;
    end
    else
    begin
      irq <= block_en_reg && ((flags_next & enable_reg) != 8'h00);
      irq_summary <= (irq_stat_reg & irq_mask_reg) != 8'h00;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb
  begin
    rdata_next = 8'h00;
    case (bus.addr)
      `AEIF_OFS_FLAGS: rdata_next = flags_reg;
      `AEIF_OFS_ENABLE: rdata_next = enable_reg;
      `AEIF_OFS_FRAMING_CTRL: rdata_next = {5'h00, crit_reg};
      `AEIF_OFS_BLOCK_EN: rdata_next = {6'h00, block_en_reg, 1'b0};
      `AEIF_OFS_STATE: rdata_next = {5'h00, oof_state, ais_state, yel_state};
      `AEIF_OFS_IRQ_STAT: rdata_next = irq_stat_reg;
      `AEIF_OFS_IRQ_MASK: rdata_next = irq_mask_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (bus.rd)
      rdata <= rdata_next;
    else
      rdata <= 8'h00;
  end
endmodule

// ---- src/aeif_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef AEIF_REGS_SVH
`define AEIF_REGS_SVH

`define AEIF_ADDR_W 4
`define AEIF_OFS_FLAGS 4'h2
`define AEIF_OFS_ENABLE 4'h3
`define AEIF_OFS_FRAMING_CTRL 4'hB
`define AEIF_OFS_STATE 4'h4
`define AEIF_OFS_BLOCK_EN 4'h1
`define AEIF_OFS_IRQ_STAT 4'h5
`define AEIF_OFS_IRQ_MASK 4'h6
`define AEIF_BIT_YEL 0
`define AEIF_BIT_AIS 1
`define AEIF_BIT_OOF 2
`define AEIF_BIT_LCV 3
`define AEIF_BIT_BLOCK_EN 1
`define AEIF_RST_FLAGS 8'h00
`define AEIF_RST_ENABLE 8'h00
`define AEIF_RST_CRIT 3'h3
`define AEIF_AIS_FRAMES 2
`define AEIF_AIS_ZERO_LIMIT 2
`define AEIF_YEL_FRAMES 2
`define AEIF_FRAME_BITS 256

`endif

// ---- src/aeif_pkg.sv ----
// types shared by the alarm and error event block
package aeif_pkg;
  typedef struct packed {
    logic frame_start;
    logic bit_valid;
    logic bit_data;
    logic fas_slot;
    logic fas_error;
    logic nfas_slot;
    logic remote_bit;
  } aeif_rx_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } aeif_bus_t;

  typedef enum logic [1:0] {
    AEIF_FR_IN,
    AEIF_FR_OUT
  } aeif_frame_state_t;
endpackage

// ---- src/aeif_detect.sv ----
// receive defect detectors: out-of-frame, all-ones alarm and remote alarm
`timescale 1ns/1ps
`include "aeif_regs.svh"

module aeif_detect
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input aeif_pkg::aeif_rx_t rx,
  input wire logic [2:0] crit,
  output logic oof_reg,
  output logic ais_reg,
  output logic yel_reg
);
  import aeif_pkg::*;

  aeif_frame_state_t fr_reg;
  logic [2:0] fas_run_reg;
  logic [8:0] zero_cnt_reg;
  logic [8:0] prev_zero_reg;
  logic [1:0] ais_frames_reg;
  logic [1:0] yel_one_reg;
  logic [1:0] yel_zero_reg;

  // ****************************************************************
  // out-of-frame
  // ****************************************************************
  // consecutive errored alignment count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fas_run_reg <= 3'h0;
      fr_reg <= AEIF_FR_IN;
    end
    else if (rx.fas_slot)
    begin
      if (!rx.fas_error)
      begin
        fas_run_reg <= 3'h0;
        fr_reg <= AEIF_FR_IN;
      end
      else
      begin
        if (fas_run_reg != 3'h7)
          fas_run_reg <= fas_run_reg + 3'h1;
        if ((fas_run_reg + 3'h1) >= crit)
          fr_reg <= AEIF_FR_OUT;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      oof_reg <= 1'b0;
    else
      case (fr_reg)
        AEIF_FR_IN: oof_reg <= 1'b0;
        AEIF_FR_OUT: oof_reg <= 1'b1;
        default: oof_reg <= 1'b0;
      endcase
  end

  // ****************************************************************
  // all-ones alarm
  // ****************************************************************
  // two frames to declare, zeros clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      zero_cnt_reg <= 9'h000;
      prev_zero_reg <= 9'h000;
      ais_frames_reg <= 2'h0;
      ais_reg <= 1'b0;
    end
    else if (rx.frame_start)
    begin
      prev_zero_reg <= zero_cnt_reg;
      zero_cnt_reg <= 9'h000;
      if (zero_cnt_reg == 9'h000)
      begin
        if (ais_frames_reg != 2'h3)
          ais_frames_reg <= ais_frames_reg + 2'h1;
        if (ais_frames_reg + 2'h1 >= 2'(`AEIF_AIS_FRAMES))
          ais_reg <= 1'b1;
      end
      else
        ais_frames_reg <= 2'h0;
      if ((zero_cnt_reg + prev_zero_reg) > 9'(`AEIF_AIS_ZERO_LIMIT))
        ais_reg <= 1'b0;
    end
    else if (rx.bit_valid && !rx.bit_data && zero_cnt_reg != 9'h1FF)
      zero_cnt_reg <= zero_cnt_reg + 9'h001;
  end

  // ****************************************************************
  // remote alarm
  // ****************************************************************
  // two non-alignment frames each way
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      yel_one_reg <= 2'h0;
      yel_zero_reg <= 2'h0;
      yel_reg <= 1'b0;
    end
    else if (rx.nfas_slot)
    begin
      if (rx.remote_bit)
      begin
        yel_zero_reg <= 2'h0;
        if (yel_one_reg != 2'h3)
          yel_one_reg <= yel_one_reg + 2'h1;
        if (yel_one_reg + 2'h1 >= 2'(`AEIF_YEL_FRAMES))
          yel_reg <= 1'b1;
      end
      else
      begin
        yel_one_reg <= 2'h0;
        if (yel_zero_reg != 2'h3)
          yel_zero_reg <= yel_zero_reg + 2'h1;
        if (yel_zero_reg + 2'h1 >= 2'(`AEIF_YEL_FRAMES))
          yel_reg <= 1'b0;
      end
    end
  end
endmodule

// ---- sim/aeif_chk.sv ----
// port assertions for the alarm and error event block
`timescale 1ns/1ps
`include "aeif_regs.svh"

module aeif_chk
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input aeif_pkg::aeif_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic line_code_violation,
  input wire logic irq
);
  import aeif_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire rd_f = bus.rd && bus.addr == `AEIF_OFS_FLAGS;
  wire rd_s = bus.rd && bus.addr == `AEIF_OFS_STATE;
  wire rd_u = bus.rd && bus.addr == 4'h0;
  wire blk_off = bus.wr && bus.addr == `AEIF_OFS_BLOCK_EN && !bus.wdata[`AEIF_BIT_BLOCK_EN];
  wire src_off = bus.wr && bus.addr == `AEIF_OFS_ENABLE && bus.wdata[3:0] == 4'h0;

  // ****
  // assertions
  // ****
  chk_read_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_flags_upper_zero: assert property ($past(rd_f) |-> rdata[7:4] == 4'h0)
    else $error("upper flag bits set");
  chk_lcv_flag_kept: assert property (line_code_violation ##1 rd_f |=> rdata[3])
    else $error("violation flag lost");
  chk_read_clears: assert property (rd_f && !line_code_violation ##1 rd_f |=> !rdata[3])
    else $error("violation flag not cleared by read");
  chk_block_mask: assert property (blk_off ##1 !bus.wr |=> !irq)
    else $error("interrupt with block enable clear");
  chk_source_mask: assert property (src_off ##1 !bus.wr |=> !irq)
    else $error("interrupt with all sources disabled");
  chk_unmapped_zero: assert property ($past(rd_u) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_state_upper_zero: assert property ($past(rd_s) |-> rdata[7:3] == 5'h00)
    else $error("upper state bits set");
  cover property (rd_f ##1 rdata[3]);
  cover property ($rose(irq));
  cover property (rd_s ##1 rdata[2]);
endmodule

bind aeif_top aeif_chk chk_u (.clk_sys, .rst_n, .bus, .rdata, .line_code_violation, .irq);

// ---- sim/aeif_top_test.sv ----
// self-checking bench for the alarm and error event block
`timescale 1ns/1ps
`include "aeif_regs.svh"

module aeif_top_test;
  import aeif_pkg::*;
  logic clk_sys = 0;
  logic rst_n = 0;
  aeif_bus_t bus = '0;
  aeif_rx_t rx = '0;
  logic lcv = 0;
  logic [7:0] rdata;
  logic irq;
  logic irq_sum;
  int n_fail = 0;
  int checked = 0;

  aeif_top dut_u (.clk_sys, .rst_n, .bus, .rdata, .line_code_violation(lcv), .rx, .irq,
    .irq_summary(irq_sum));

  always #5 clk_sys = ~clk_sys;

  // ****
  // tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus.wr <= 1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_sys);
    bus.wr <= 0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus.rd <= 1;
    bus.addr <= a;
    @(posedge clk_sys);
    bus.rd <= 0;
    #1;
    check(rdata, exp);
  endtask

  // violation pulse, optionally beside a clearing read
  task automatic hit(input logic r);
    @(posedge clk_sys);
    lcv <= 1;
    bus.rd <= r;
    bus.addr <= `AEIF_OFS_FLAGS;
    @(posedge clk_sys);
    lcv <= 0;
    bus.rd <= 0;
  endtask

  // margin lets the detector and flag stages settle
  task automatic rxp(input logic [6:0] v);
    @(posedge clk_sys);
    rx <= v;
    @(posedge clk_sys);
    rx <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic frames(input logic d);
    repeat (4)
      for (int b = 0; b < `AEIF_FRAME_BITS; b++)
      begin
        @(posedge clk_sys);
        rx <= {b == 0, 1'b1, d, 4'h0};
      end
    @(posedge clk_sys);
    rx <= '0;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, irq}, {7'h00, e});
  endtask

  task automatic sum_is(input logic e);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, irq_sum}, {7'h00, e});
  endtask

  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    n_fail++;
    end_of_test;
  end

  // ****
  // tests
  // ****
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    rd(`AEIF_OFS_FLAGS, 8'h00);
    rd(`AEIF_OFS_FRAMING_CTRL, 8'h03);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    $display("test reset done");
    hit(0);
    rd(`AEIF_OFS_FLAGS, 8'h08);
    rd(`AEIF_OFS_FLAGS, 8'h00);
    hit(1);
    rd(`AEIF_OFS_FLAGS, 8'h08);
    $display("test violation done");
    rxp(7'h03);
    rd(`AEIF_OFS_FLAGS, 8'h00);
    rxp(7'h03);
    rd(`AEIF_OFS_FLAGS, 8'h01);
    rd(`AEIF_OFS_STATE, 8'h01);
    rxp(7'h02);
    rxp(7'h02);
    rd(`AEIF_OFS_FLAGS, 8'h01);
    rd(`AEIF_OFS_STATE, 8'h00);
    $display("test remote alarm done");
    frames(1);
    rd(`AEIF_OFS_FLAGS, 8'h02);
    rd(`AEIF_OFS_STATE, 8'h02);
    frames(0);
    rd(`AEIF_OFS_FLAGS, 8'h02);
    rd(`AEIF_OFS_STATE, 8'h00);
    $display("test all ones done");
    wr(`AEIF_OFS_FRAMING_CTRL, 8'h02);
    rd(`AEIF_OFS_FRAMING_CTRL, 8'h02);
    rxp(7'h0C);
    rd(`AEIF_OFS_STATE, 8'h00);
    rxp(7'h0C);
    rd(`AEIF_OFS_STATE, 8'h04);
    rd(`AEIF_OFS_FLAGS, 8'h04);
    $display("test frame loss done");
    wr(`AEIF_OFS_BLOCK_EN, 8'h02);
    hit(0);
    irq_is(0);
    wr(`AEIF_OFS_ENABLE, 8'h08);
    rd(`AEIF_OFS_ENABLE, 8'h08);
    irq_is(1);
    wr(`AEIF_OFS_BLOCK_EN, 8'h00);
    irq_is(0);
    wr(`AEIF_OFS_BLOCK_EN, 8'h02);
    irq_is(1);
    rd(`AEIF_OFS_FLAGS, 8'h08);
    irq_is(0);
    $display("test interrupt done");
    // sticky summary kept every event seen so far
    rd(`AEIF_OFS_IRQ_STAT, 8'h0F);
    sum_is(0);
    wr(`AEIF_OFS_IRQ_MASK, 8'h08);
    sum_is(1);
    wr(`AEIF_OFS_IRQ_STAT, 8'h0F);
    sum_is(0);
    rd(`AEIF_OFS_IRQ_STAT, 8'h00);
    $display("test summary done");
    end_of_test;
  end
endmodule
